/* src/cfdt_pkg.sv */
package cfdt_pkg;
    localparam int LEN_W = 3;
    localparam int CYC_W = 5;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int ABS_W = 24;
    localparam int DEC_BYTES = 4;
    localparam int REL_ONE = 1;
    localparam int REL_TWO = 2;
    localparam int CNT_LAST = 1;

    typedef enum logic [3:0] {
        CL_NONE, CL_DEC_SUB, CL_FRAME_EXIT, CL_SW_INT, CL_OVF_TRAP, CL_COND_JUMP,
        CL_SHORT_JUMP, CL_IND_JUMP, CL_SIGN_EXT, CL_BYTE_INC, CL_CALL, CL_UNDEF
    } cfdt_class_e;
    typedef logic [LEN_W-1:0] cfdt_len_t;
    typedef logic [CYC_W-1:0] cfdt_cyc_t;

    // Opcode bytes and fields
    localparam logic [7:0] OPC_PFX_BYTE = 8'h7C;
    localparam logic [7:0] OPC_PFX_WORD = 8'h7D;
    localparam logic [7:0] OPC2_DEC_SUB_IMM = 8'hED;
    localparam logic [7:0] OPC2_DEC_SUB_REG = 8'hE5;
    localparam logic [7:0] OPC2_FRAME_EXIT = 8'hF0;
    localparam logic [7:0] OPC2_SEXT_WORD = 8'hF3;
    localparam logic [3:0] OPC2_CJX_HI = 4'h8;
    localparam logic [3:0] OPC2_IJW_HI = 4'h1;
    localparam logic [3:0] OPC2_IJA_HI = 4'h3;
    localparam logic [3:0] OPC2_SEXT_HI = 4'h4;
    localparam logic [7:0] OPC_SW_INT = 8'hEB;
    localparam logic [7:0] OPC_OVF_TRAP = 8'hF7;
    localparam logic [4:0] OPC_CJ_HI = 5'h1A;
    localparam logic [4:0] OPC_SJ_HI = 5'h0C;
    localparam logic [4:0] OPC_INC_HI = 5'h14;
    localparam logic [7:0] OPC_CALL_W = 8'hF4;
    localparam logic [7:0] OPC_CALL_A = 8'hFC;

    // Operand codes
    localparam logic [3:0] SRC_MEM_FIRST = 4'h6;
    localparam logic [3:0] SRC_DSP8_FIRST = 4'h8;
    localparam logic [3:0] SRC_DSP16_FIRST = 4'hC;
    localparam logic [3:0] SRC_SB16_FIRST = 4'hE;
    localparam logic [15:0] IJA_BAD = 16'h002C;
    localparam logic [15:0] SEXT_BAD = 16'h003A;
    localparam logic [2:0] INC_DST_HI = 3'h3;
    localparam logic [2:0] INC_DST_LO = 3'h4;
    localparam logic [2:0] INC_DST_SB = 3'h5;
    localparam logic [2:0] INC_DST_ABS = 3'h7;

    // Condition codes
    localparam logic [3:0] CND_GEU = 4'h0;
    localparam logic [3:0] CND_GTU = 4'h1;
    localparam logic [3:0] CND_EQ = 4'h2;
    localparam logic [3:0] CND_N = 4'h3;
    localparam logic [3:0] CND_LTU = 4'h4;
    localparam logic [3:0] CND_LEU = 4'h5;
    localparam logic [3:0] CND_NE = 4'h6;
    localparam logic [3:0] CND_PZ = 4'h7;
    localparam logic [3:0] CND_LE = 4'h8;
    localparam logic [3:0] CND_O = 4'h9;
    localparam logic [3:0] CND_GE = 4'hA;
    localparam logic [3:0] CND_GT = 4'hC;
    localparam logic [3:0] CND_NO = 4'hD;
    localparam logic [3:0] CND_LT = 4'hE;

    // Lengths and cycle counts
    localparam cfdt_len_t LEN_OP1 = 3'h1;
    localparam cfdt_len_t LEN_OP2 = 3'h2;
    localparam cfdt_len_t LEN_OP3 = 3'h3;
    localparam cfdt_len_t LEN_OP4 = 3'h4;
    localparam cfdt_len_t LEN_OP5 = 3'h5;
    localparam cfdt_cyc_t CYC_UNDEF = 5'h01;
    localparam cfdt_cyc_t CYC_DEC_SUB = 5'h04;
    localparam cfdt_cyc_t CYC_FRAME_EXIT = 5'h09;
    localparam cfdt_cyc_t CYC_SW_INT = 5'h13;
    localparam cfdt_cyc_t CYC_OVF_TRAP = 5'h01;
    localparam cfdt_cyc_t CYC_OVF_ADD = 5'h13;
    localparam cfdt_cyc_t CYC_CJ_BASE = 5'h02;
    localparam cfdt_cyc_t CYC_CJ_TAKEN = 5'h02;
    localparam cfdt_cyc_t CYC_SJ = 5'h05;
    localparam cfdt_cyc_t CYC_IJW_REG = 5'h07;
    localparam cfdt_cyc_t CYC_IJW_MEM = 5'h0B;
    localparam cfdt_cyc_t CYC_IJA_REG = 5'h06;
    localparam cfdt_cyc_t CYC_IJA_MEM = 5'h0A;
    localparam cfdt_cyc_t CYC_SEXT_REG = 5'h03;
    localparam cfdt_cyc_t CYC_SEXT_MEM = 5'h05;
    localparam cfdt_cyc_t CYC_INC_REG = 5'h01;
    localparam cfdt_cyc_t CYC_INC_MEM = 5'h03;
    localparam cfdt_cyc_t CYC_CALL_W = 5'h08;
    localparam cfdt_cyc_t CYC_CALL_A = 5'h09;
endpackage : cfdt_pkg

/* src/cfdt_cycle_timer.sv */
`timescale 1ns/1ps
module cfdt_cycle_timer import cfdt_pkg::*; #(
    parameter int CW = CYC_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CW-1:0] load_count,
    output logic busy,
    output logic done
);
    logic [CW-1:0] count_d;
    logic [CW-1:0] count_q;

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_count;
        end else if (count_q != '0) begin
            count_d = count_q - CW'(CNT_LAST);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign busy = (count_q != '0);
    assign done = (count_q == CW'(CNT_LAST));
endmodule : cfdt_cycle_timer

/* src/cfdt_cond_eval.sv */
`timescale 1ns/1ps
module cfdt_cond_eval import cfdt_pkg::*; (
    input wire logic [3:0] cond,
    input wire logic ext,
    input wire logic flag_c,
    input wire logic flag_z,
    input wire logic flag_s,
    input wire logic flag_o,
    output logic taken,
    output logic legal
);
    logic lt;

    assign lt = flag_s ^ flag_o;

    // Short form owns codes 0-7, extended form 8-A and C-E; the two never overlap
    always_comb begin
        taken = 1'b0;
        legal = (ext == cond[3]);
        unique case (cond)
            CND_GEU: taken = flag_c;
            CND_GTU: taken = flag_c & ~flag_z;
            CND_EQ: taken = flag_z;
            CND_N: taken = flag_s;
            CND_LTU: taken = ~flag_c;
            CND_LEU: taken = ~(flag_c & ~flag_z);
            CND_NE: taken = ~flag_z;
            CND_PZ: taken = ~flag_s;
            CND_LE: taken = lt | flag_z;
            CND_O: taken = flag_o;
            CND_GE: taken = ~lt;
            CND_GT: taken = ~(lt | flag_z);
            CND_NO: taken = ~flag_o;
            CND_LT: taken = lt;
            default: legal = 1'b0;
        endcase
    end
endmodule : cfdt_cond_eval

/* src/cfdt_decoder.sv */
`timescale 1ns/1ps
// Functional notes
// - Word decimal subtract: four bytes, four cycles
// - Frame exit return: two bytes, nine cycles
// - Software interrupt EB: two bytes, nineteen cycles
// - Overflow trap: one cycle, nineteen more if taken
// - Short conditional jump: start+1+dsp8, 3-bit condition
// - Conditional jump: two cycles, two more if taken
// - Extended condition codes from 4-bit table
// - Extended conditional jump target: start+2+dsp8
// - Short jump 01100+dsp3 from start+2, five cycles
// - Word indirect jump: seven register, eleven memory cycles
// - Address indirect jump rejects 0010/0011/0101; 6/10 cycles
// - Sign extend rejects 0001/0011/0100/0101; 3/5 cycles
// - Byte increment 3-bit destination; register one byte/cycle
// - Relative call: dsp16 from start+1, three bytes, eight cycles
// - Absolute call: four bytes, nine cycles
module cfdt_decoder import cfdt_pkg::*; #(
    parameter int AW = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ins_valid,
    output logic ins_ready,
    input wire logic [DEC_BYTES*BYTE_W-1:0] ins_bytes,
    input wire logic [AW-1:0] ins_addr,
    input wire logic flag_c,
    input wire logic flag_z,
    input wire logic flag_s,
    input wire logic flag_o,
    output cfdt_class_e dec_class,
    output cfdt_len_t dec_len,
    output cfdt_cyc_t dec_cycles,
    output logic dec_branch,
    output logic dec_tgt_valid,
    output logic [AW-1:0] dec_target,
    output logic dec_trap,
    output logic dec_undef,
    output logic exec_busy,
    output logic exec_done
);
    logic acc;
    logic pfx_w;
    logic [BYTE_W-1:0] ib [DEC_BYTES];
    logic [3:0] opd;
    logic [2:0] sj_dsp;
    logic [AW-1:0] sx_b1;
    logic [AW-1:0] sx_b2;
    logic [AW-1:0] sx_w16;
    logic [ABS_W-1:0] abs_addr;
    logic [3:0] cnd;
    logic cnd_taken;
    logic cnd_legal;
    cfdt_class_e cls_d;
    cfdt_class_e cls_q;
    cfdt_len_t len_d;
    cfdt_len_t len_q;
    cfdt_cyc_t cyc_d;
    cfdt_cyc_t cyc_q;
    logic br_d;
    logic br_q;
    logic tv_d;
    logic tv_q;
    logic trap_d;
    logic trap_q;
    logic undef_d;
    logic undef_q;
    logic [AW-1:0] tgt_d;
    logic [AW-1:0] tgt_q;

    function automatic logic opd_mem(input logic [3:0] code);
        return code >= SRC_MEM_FIRST;
    endfunction : opd_mem

    // Only the indirect jump forms carry a 20-bit displacement
    function automatic cfdt_len_t src_len(input logic [3:0] code, input logic dsp20);
        cfdt_len_t len;
        if (code < SRC_DSP8_FIRST) begin
            len = LEN_OP2;
        end else if (code < SRC_DSP16_FIRST) begin
            len = LEN_OP3;
        end else if (code < SRC_SB16_FIRST) begin
            len = dsp20 ? LEN_OP5 : LEN_OP4;
        end else begin
            len = LEN_OP4;
        end
        return len;
    endfunction : src_len

    for (genvar i = 0; i < DEC_BYTES; i++) begin : g_byte
        assign ib[i] = ins_bytes[i*BYTE_W +: BYTE_W];
    end

    assign pfx_w = (ib[0] == OPC_PFX_WORD);
    assign opd = ib[1][3:0];
    assign sj_dsp = ib[0][2:0];
    assign sx_b1 = {{(AW-BYTE_W){ib[1][BYTE_W-1]}}, ib[1]};
    assign sx_b2 = {{(AW-BYTE_W){ib[2][BYTE_W-1]}}, ib[2]};
    assign sx_w16 = {{(AW-WORD_W){ib[2][BYTE_W-1]}}, ib[2], ib[1]};
    assign abs_addr = {ib[3], ib[2], ib[1]};
    assign cnd = pfx_w ? opd : {1'b0, sj_dsp};
    assign ins_ready = ~exec_busy;
    assign acc = ins_valid & ins_ready;

    cfdt_cond_eval u_cond (
        .cond(cnd),
        .ext(pfx_w),
        .flag_c(flag_c),
        .flag_z(flag_z),
        .flag_s(flag_s),
        .flag_o(flag_o),
        .taken(cnd_taken),
        .legal(cnd_legal)
    );

    // Flags are sampled in the accept cycle; the executing core need not hold them afterwards
    always_comb begin
        cls_d = cls_q;
        len_d = len_q;
        cyc_d = cyc_q;
        br_d = br_q;
        tv_d = tv_q;
        tgt_d = tgt_q;
        trap_d = trap_q;
        undef_d = undef_q;
        if (acc) begin
            cls_d = CL_UNDEF;
            len_d = LEN_OP1;
            cyc_d = CYC_UNDEF;
            br_d = 1'b0;
            tv_d = 1'b0;
            tgt_d = '0;
            trap_d = 1'b0;
            if (ib[0] == OPC_PFX_BYTE || pfx_w) begin
                len_d = LEN_OP2;
                if (ib[1] == OPC2_DEC_SUB_IMM) begin
                    cls_d = CL_DEC_SUB;
                    len_d = pfx_w ? LEN_OP4 : LEN_OP3;
                    cyc_d = CYC_DEC_SUB;
                end else if (ib[1] == OPC2_DEC_SUB_REG) begin
                    cls_d = CL_DEC_SUB;
                    cyc_d = CYC_DEC_SUB;
                end else if (pfx_w && ib[1] == OPC2_FRAME_EXIT) begin
                    cls_d = CL_FRAME_EXIT;
                    cyc_d = CYC_FRAME_EXIT;
                    br_d = 1'b1;
                end else if (pfx_w && ib[1][7:4] == OPC2_CJX_HI) begin
                    if (cnd_legal) begin
                        cls_d = CL_COND_JUMP;
                        len_d = LEN_OP3;
                        cyc_d = cnd_taken ? CYC_CJ_BASE + CYC_CJ_TAKEN : CYC_CJ_BASE;
                        br_d = cnd_taken;
                        tv_d = cnd_taken;
                        tgt_d = ins_addr + AW'(REL_TWO) + sx_b2;
                    end
                end else if (pfx_w && ib[1][7:4] == OPC2_IJW_HI) begin
                    cls_d = CL_IND_JUMP;
                    len_d = src_len(opd, 1'b1);
                    cyc_d = opd_mem(opd) ? CYC_IJW_MEM : CYC_IJW_REG;
                    br_d = 1'b1;
                end else if (pfx_w && ib[1][7:4] == OPC2_IJA_HI && !IJA_BAD[opd]) begin
                    cls_d = CL_IND_JUMP;
                    len_d = src_len(opd, 1'b1);
                    cyc_d = opd_mem(opd) ? CYC_IJA_MEM : CYC_IJA_REG;
                    br_d = 1'b1;
                end else if (!pfx_w && ib[1][7:4] == OPC2_SEXT_HI && !SEXT_BAD[opd]) begin
                    cls_d = CL_SIGN_EXT;
                    len_d = src_len(opd, 1'b0);
                    cyc_d = opd_mem(opd) ? CYC_SEXT_MEM : CYC_SEXT_REG;
                end else if (!pfx_w && ib[1] == OPC2_SEXT_WORD) begin
                    cls_d = CL_SIGN_EXT;
                    cyc_d = CYC_SEXT_REG;
                end
            end else if (ib[0] == OPC_SW_INT) begin
                cls_d = CL_SW_INT;
                len_d = LEN_OP2;
                cyc_d = CYC_SW_INT;
                trap_d = 1'b1;
            end else if (ib[0] == OPC_OVF_TRAP) begin
                cls_d = CL_OVF_TRAP;
                cyc_d = flag_o ? CYC_OVF_TRAP + CYC_OVF_ADD : CYC_OVF_TRAP;
                trap_d = flag_o;
            end else if (ib[0][7:3] == OPC_CJ_HI) begin
                cls_d = CL_COND_JUMP;
                len_d = LEN_OP2;
                cyc_d = cnd_taken ? CYC_CJ_BASE + CYC_CJ_TAKEN : CYC_CJ_BASE;
                br_d = cnd_taken;
                tv_d = cnd_taken;
                tgt_d = ins_addr + AW'(REL_ONE) + sx_b1;
            end else if (ib[0][7:3] == OPC_SJ_HI) begin
                cls_d = CL_SHORT_JUMP;
                cyc_d = CYC_SJ;
                br_d = 1'b1;
                tv_d = 1'b1;
                tgt_d = ins_addr + AW'(REL_TWO) + AW'(sj_dsp);
            end else if (ib[0][7:3] == OPC_INC_HI && sj_dsp >= INC_DST_HI) begin
                cls_d = CL_BYTE_INC;
                if (sj_dsp < INC_DST_SB) begin
                    cyc_d = CYC_INC_REG;
                end else begin
                    len_d = (sj_dsp == INC_DST_ABS) ? LEN_OP3 : LEN_OP2;
                    cyc_d = CYC_INC_MEM;
                end
            end else if (ib[0] == OPC_CALL_W) begin
                cls_d = CL_CALL;
                len_d = LEN_OP3;
                cyc_d = CYC_CALL_W;
                br_d = 1'b1;
                tv_d = 1'b1;
                tgt_d = ins_addr + AW'(REL_ONE) + sx_w16;
            end else if (ib[0] == OPC_CALL_A) begin
                cls_d = CL_CALL;
                len_d = LEN_OP4;
                cyc_d = CYC_CALL_A;
                br_d = 1'b1;
                tv_d = 1'b1;
                tgt_d = abs_addr[AW-1:0];
            end
            // Undefined keeps no branch and no trap, so nothing partial leaks out
            undef_d = (cls_d == CL_UNDEF);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cls_q <= CL_NONE;
            len_q <= '0;
            cyc_q <= '0;
            br_q <= 1'b0;
            tv_q <= 1'b0;
            tgt_q <= '0;
            trap_q <= 1'b0;
            undef_q <= 1'b0;
        end else begin
            cls_q <= cls_d;
            len_q <= len_d;
            cyc_q <= cyc_d;
            br_q <= br_d;
            tv_q <= tv_d;
            tgt_q <= tgt_d;
            trap_q <= trap_d;
            undef_q <= undef_d;
        end
    end

    // Timer owns the instruction for exactly its cycle count
    cfdt_cycle_timer #(
        .CW(CYC_W)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(acc),
        .load_count(cyc_d),
        .busy(exec_busy),
        .done(exec_done)
    );

    assign dec_class = cls_q;
    assign dec_len = len_q;
    assign dec_cycles = cyc_q;
    assign dec_branch = br_q;
    assign dec_tgt_valid = tv_q;
    assign dec_target = tgt_q;
    assign dec_trap = trap_q;
    assign dec_undef = undef_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_DEC_SUB_WORD: assert property (
        (acc && pfx_w && ib[1] == OPC2_DEC_SUB_IMM)
        |=> (dec_len == LEN_OP4 && dec_cycles == CYC_DEC_SUB && !exec_done) ##3 exec_done
    ) else $error("word decimal subtract length or timing wrong");

    AST_FRAME_EXIT: assert property (
        (acc && pfx_w && ib[1] == OPC2_FRAME_EXIT)
        |=> (dec_len == LEN_OP2 && !exec_done) ##1 (!exec_done)[*7] ##1 exec_done
    ) else $error("frame exit not nine cycles");

    AST_SW_INT: assert property (
        (acc && ib[0] == OPC_SW_INT)
        |=> (dec_trap && dec_len == LEN_OP2) ##18 exec_done
    ) else $error("software interrupt not nineteen cycles");

    AST_OVF_TAKEN: assert property (
        (acc && ib[0] == OPC_OVF_TRAP && flag_o) |=> dec_trap ##19 exec_done
    ) else $error("taken overflow trap not twenty cycles");

    AST_OVF_CLEAR: assert property (
        (acc && ib[0] == OPC_OVF_TRAP && !flag_o)
        |=> exec_done && !dec_trap && dec_len == LEN_OP1
    ) else $error("untaken overflow trap not one cycle");

    AST_CJ_SHORT: assert property (
        (acc && ib[0][7:3] == OPC_CJ_HI) |=> dec_len == LEN_OP2 &&
        (!dec_branch || dec_target == $past(ins_addr) + AW'(REL_ONE) + $past(sx_b1))
    ) else $error("short conditional jump target wrong");

    AST_CJ_CYCLES: assert property (
        (acc && ib[0][7:3] == OPC_CJ_HI)
        |=> dec_cycles == (dec_branch ? CYC_CJ_BASE + CYC_CJ_TAKEN : CYC_CJ_BASE)
    ) else $error("conditional jump cycle count wrong");

    AST_CJ_OVF: assert property (
        (acc && pfx_w && ib[1] == {OPC2_CJX_HI, CND_O} && flag_o)
        |=> (dec_branch && dec_len == LEN_OP3) ##3 exec_done
    ) else $error("extended overflow jump not taken in four cycles");

    AST_CJ_EXT_TGT: assert property (
        (acc && pfx_w && ib[1][7:4] == OPC2_CJX_HI) |=>
        (!dec_branch || dec_target == $past(ins_addr) + AW'(REL_TWO) + $past(sx_b2))
    ) else $error("extended conditional jump target wrong");

    AST_SHORT_JUMP: assert property (
        (acc && ib[0][7:3] == OPC_SJ_HI)
        |=> (dec_target == $past(ins_addr) + AW'(REL_TWO) + AW'($past(sj_dsp)))
        ##4 exec_done
    ) else $error("short jump target or timing wrong");

    AST_IJW_REG: assert property (
        (acc && pfx_w && ib[1][7:4] == OPC2_IJW_HI && !opd_mem(opd))
        |=> (dec_branch && dec_len == LEN_OP2) ##6 exec_done
    ) else $error("word indirect jump register timing wrong");

    AST_IJA_BAD: assert property (
        (acc && pfx_w && ib[1][7:4] == OPC2_IJA_HI && IJA_BAD[opd])
        |=> dec_undef && !dec_branch && exec_done
    ) else $error("address indirect jump accepted bad source");

    AST_IJA_MEM: assert property (
        (acc && pfx_w && ib[1][7:4] == OPC2_IJA_HI && opd_mem(opd))
        |=> dec_cycles == CYC_IJA_MEM ##9 exec_done
    ) else $error("address indirect jump memory timing wrong");

    AST_SEXT_BAD: assert property (
        (acc && ib[0] == OPC_PFX_BYTE && ib[1][7:4] == OPC2_SEXT_HI && SEXT_BAD[opd])
        |=> dec_undef && exec_done
    ) else $error("sign extend accepted bad destination");

    AST_INC_REG: assert property (
        (acc && ib[0][7:3] == OPC_INC_HI && (sj_dsp == INC_DST_HI || sj_dsp == INC_DST_LO))
        |=> exec_done && dec_len == LEN_OP1 && !dec_undef
    ) else $error("register byte increment not one byte one cycle");

    AST_CALL_W: assert property (
        (acc && ib[0] == OPC_CALL_W)
        |=> (dec_target == $past(ins_addr) + AW'(REL_ONE) + $past(sx_w16)) ##7 exec_done
    ) else $error("relative call target or timing wrong");

    AST_CALL_A: assert property (
        (acc && ib[0] == OPC_CALL_A) |=> dec_len == LEN_OP4 ##8 exec_done
    ) else $error("absolute call not nine cycles");

    AST_UNDEF_INERT: assert property (
        (acc ##1 dec_undef) |-> !dec_branch && !dec_tgt_valid && !dec_trap && exec_done
    ) else $error("undefined instruction did partial work");

    COV_CJX_TAKEN: cover property (acc && pfx_w && ib[1][7:4] == OPC2_CJX_HI ##1 dec_branch);
    COV_OVF_TAKEN: cover property (acc && ib[0] == OPC_OVF_TRAP && flag_o);
    COV_UNDEF: cover property (acc ##1 dec_undef);
    COV_BACK2BACK: cover property (exec_done ##1 acc);
endmodule : cfdt_decoder

/* testbench/cfdt_prog_mem.sv */
`timescale 1ns/1ps
module cfdt_prog_mem import cfdt_pkg::*; #(
    parameter int AW = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [AW+39:0] push_item,
    input wire logic ins_ready,
    output logic ins_valid,
    output logic [31:0] ins_bytes,
    output logic [AW-1:0] ins_addr,
    output logic [3:0] flags
);
    // Item is gap, flags {c,z,s,o}, start address, bytes
    logic [AW+39:0] q[$];
    logic [3:0] idle_q;
    initial begin
        ins_valid = 1'b0;
        ins_bytes = 32'h0;
        ins_addr = '0;
        flags = 4'h0;
        idle_q = 4'h0;
    end
    always @(posedge core_clk) begin
        if (push) q.push_back(push_item);
        if (!rst_n) begin
            ins_valid <= 1'b0;
            idle_q <= 4'h0;
        end else if (ins_valid && ins_ready) begin
            ins_valid <= 1'b0;
            ins_bytes <= ~ins_bytes;
        end else if (!ins_valid) begin
            // Idle bus toggles so stale bytes are never mistaken for a fetch
            ins_bytes <= ~ins_bytes;
            idle_q <= idle_q + 4'h1;
            if (q.size() != 0 && idle_q >= q[0][AW+39:AW+36]) begin
                {flags, ins_addr, ins_bytes} <= q[0][AW+35:0];
                ins_valid <= 1'b1;
                idle_q <= 4'h0;
                void'(q.pop_front());
            end
        end
    end
endmodule : cfdt_prog_mem

/* testbench/test_cfdt_decoder.sv */
`timescale 1ns/1ps
module test_cfdt_decoder import cfdt_pkg::*;;
    localparam int AW = 20;
    typedef struct packed {
        cfdt_class_e cls;
        cfdt_len_t len;
        cfdt_cyc_t cyc;
        logic [1:0] br;
        logic tv;
        logic [AW-1:0] tgt;
        logic trap;
        logic undef;
    } cfdt_tb_exp_s;
    logic core_clk = 1'b0, rst_n = 1'b0;
    logic push = 1'b0;
    logic [AW+39:0] item = '0;
    logic ins_valid, ins_ready, dec_branch, dec_tgt_valid, dec_trap, dec_undef;
    logic exec_busy, exec_done;
    logic [31:0] ins_bytes, seed, b;
    logic [AW-1:0] ins_addr, dec_target;
    logic [3:0] flags;
    cfdt_class_e dec_class;
    cfdt_len_t dec_len;
    cfdt_cyc_t dec_cycles;
    cfdt_tb_exp_s exp_q[$], e;
    int num_errors = 0;
    int tests_run = 0;
    int cnt = 0;
    logic [31:0] tpl[14] = '{32'hED7D, 32'hED7C, 32'hF07D, 32'hEB, 32'hF7, 32'hD0, 32'h807D,
        32'h60, 32'h107D, 32'h307D, 32'h407C, 32'hA0, 32'hF4, 32'hFC};
    logic [31:0] msk[14] = '{32'hFFFF0000, 32'hFFFF0000, 32'hFFFF0000, 32'hFFFFFF00,
        32'hFFFFFF00, 32'hFFFFFF07, 32'hFFFF0F00, 32'hFFFFFF07, 32'hFFFF0F00, 32'hFFFF0F00,
        32'hFFFF0F00, 32'hFFFFFF07, 32'hFFFFFF00, 32'hFFFFFF00};

    always #2 core_clk = ~core_clk;

    cfdt_prog_mem #(.AW(AW)) u_pm (.core_clk(core_clk), .rst_n(rst_n), .push(push),
        .push_item(item), .ins_ready(ins_ready), .ins_valid(ins_valid), .ins_bytes(ins_bytes),
        .ins_addr(ins_addr), .flags(flags));
    cfdt_decoder #(.AW(AW)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .ins_valid(ins_valid),
        .ins_ready(ins_ready), .ins_bytes(ins_bytes), .ins_addr(ins_addr), .flag_c(flags[3]),
        .flag_z(flags[2]), .flag_s(flags[1]), .flag_o(flags[0]), .dec_class(dec_class),
        .dec_len(dec_len), .dec_cycles(dec_cycles), .dec_branch(dec_branch),
        .dec_tgt_valid(dec_tgt_valid), .dec_target(dec_target), .dec_trap(dec_trap),
        .dec_undef(dec_undef), .exec_busy(exec_busy), .exec_done(exec_done));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    function automatic logic cnd(input logic [3:0] k, input logic [3:0] f);
        logic c, z, s, o;
        logic [15:0] t;
        {c, z, s, o} = f;
        t = {1'b0, s ^ o, ~o, ~((s ^ o) | z), 1'b0, ~(s ^ o), o, (s ^ o) | z, ~s, ~z,
            ~(c & ~z), ~c, s, z, c & ~z, c};
        return t[k];
    endfunction : cnd

    function automatic cfdt_len_t ilen(input logic [3:0] lo);
        return (lo < 4'h8) ? 3'h2 : (lo < 4'hC) ? 3'h3 : (lo < 4'hE) ? 3'h5 : 3'h4;
    endfunction : ilen

    function automatic cfdt_tb_exp_s model(input logic [31:0] b, input logic [AW-1:0] a,
            input logic [3:0] f);
        logic [3:0] lo;
        logic [2:0] d;
        logic tk;
        logic [7:0] op;
        cfdt_tb_exp_s e;
        lo = b[11:8];
        d = b[2:0];
        op = b[7:0];
        e = '{CL_UNDEF, (b[7:1] == 7'h3E) ? 3'h2 : 3'h1, 5'h01, 2'h0, 1'b0, '0, 1'b0, 1'b1};
        if (b[15:0] == 16'hED7D) e = '{CL_DEC_SUB, 3'h4, 5'h04, 2'h0, 1'b0, '0, 1'b0, 1'b0};
        else if (b[15:0] == 16'hED7C) e = '{CL_DEC_SUB, 3'h3, 5'h04, 2'h0, 1'b0, '0, 1'b0, 1'b0};
        else if (b[15:0] == 16'hF07D) e = '{CL_FRAME_EXIT, 3'h2, 5'h09, 2'h1, 1'b0, '0, 1'b0, 1'b0};
        else if (op == 8'hEB) e = '{CL_SW_INT, 3'h2, 5'h13, 2'h2, 1'b0, '0, 1'b1, 1'b0};
        else if (op == 8'hF7) e = '{CL_OVF_TRAP, 3'h1, f[0] ? 5'h14 : 5'h01, 2'h2, 1'b0, '0, f[0], 1'b0};
        else if (b[7:3] == 5'h1A) begin
            tk = cnd({1'b0, d}, f);
            e = '{CL_COND_JUMP, 3'h2, tk ? 5'h04 : 5'h02, {1'b0, tk}, tk,
                a + AW'(1) + {{(AW-8){b[15]}}, b[15:8]}, 1'b0, 1'b0};
        end else if (op == 8'h7D && b[15:12] == 4'h8 && lo inside {4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE}) begin
            tk = cnd(lo, f);
            e = '{CL_COND_JUMP, 3'h3, tk ? 5'h04 : 5'h02, {1'b0, tk}, tk,
                a + AW'(2) + {{(AW-8){b[23]}}, b[23:16]}, 1'b0, 1'b0};
        end else if (b[7:3] == 5'h0C) e = '{CL_SHORT_JUMP, 3'h1, 5'h05, 2'h1, 1'b1, a + AW'(2) + AW'(d), 1'b0, 1'b0};
        else if (op == 8'h7D && b[15:12] == 4'h1) e = '{CL_IND_JUMP, ilen(lo), (lo < 4'h6) ? 5'h07 : 5'h0B, 2'h1, 1'b0, '0, 1'b0, 1'b0};
        else if (op == 8'h7D && b[15:12] == 4'h3 && !(lo inside {4'h2, 4'h3, 4'h5})) e = '{CL_IND_JUMP, ilen(lo), (lo < 4'h6) ? 5'h06 : 5'h0A, 2'h1, 1'b0, '0, 1'b0, 1'b0};
        else if (op == 8'h7C && b[15:12] == 4'h4 && !(lo inside {4'h1, 4'h3, 4'h4, 4'h5})) e = '{CL_SIGN_EXT, (lo < 4'h8) ? 3'h2 : (lo < 4'hC) ? 3'h3 : 3'h4, (lo < 4'h6) ? 5'h03 : 5'h05, 2'h0, 1'b0, '0, 1'b0, 1'b0};
        else if (b[7:3] == 5'h14 && d >= 3'h3) e = '{CL_BYTE_INC, (d < 3'h5) ? 3'h1 : (d < 3'h7) ? 3'h2 : 3'h3, (d < 3'h5) ? 5'h01 : 5'h03, 2'h0, 1'b0, '0, 1'b0, 1'b0};
        else if (op == 8'hF4) e = '{CL_CALL, 3'h3, 5'h08, 2'h1, 1'b1, a + AW'(1) + {{(AW-16){b[23]}}, b[23:8]}, 1'b0, 1'b0};
        else if (op == 8'hFC) e = '{CL_CALL, 3'h4, 5'h09, 2'h1, 1'b1, b[AW+7:8], 1'b0, 1'b0};
        return e;
    endfunction : model

    task automatic check(input string what, input logic [31:0] exp_v, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp_v) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp_v, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Cycle count runs from the accept edge to the edge that samples the done pulse
    always @(posedge core_clk) begin
        cnt = cnt + 1;
        if (rst_n && exec_done === 1'b1) begin
            if (exp_q.size() == 0) check("spurious done", 32'h0, 32'h1);
            else begin
                e = exp_q.pop_front();
                check("class", 32'(e.cls), 32'(dec_class));
                check("length", 32'(e.len), 32'(dec_len));
                check("cycles", 32'(e.cyc), 32'(dec_cycles));
                check("done cycle", 32'(e.cyc), cnt);
                check("trap", 32'(e.trap), 32'(dec_trap));
                check("undefined", 32'(e.undef), 32'(dec_undef));
                if (e.br != 2'h2) check("branch", 32'(e.br), 32'(dec_branch));
                check("target", 32'(e.tgt), 32'(dec_target));
                check("target valid", 32'(e.tv), 32'(dec_tgt_valid));
                check("busy", 32'h1, 32'(exec_busy));
            end
        end
        if (ins_valid === 1'b1 && ins_ready === 1'b1) cnt = 0;
    end

    initial begin
        seed = 32'hC1AA;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check("reset class", 32'(CL_NONE), 32'(dec_class));
        check("reset ready", 32'h1, 32'(ins_ready));
        $display("test reset done");
        for (int t = 0; t < 14; t++) begin
            for (int j = 0; j < 16; j++) begin
                seed = lfsr_next(seed);
                b = (seed & msk[t] & ~32'hF07) | tpl[t] |
                    (msk[t] & 32'hF07 & {20'h0, j[3:0], 5'h0, j[2:0]});
                seed = lfsr_next(seed);
                exp_q.push_back(model(b, seed[AW+7:8], seed[3:0]));
                // Mostly back to back, now and then a slow fetch
                item <= {(j[1:0] == 2'h0) ? seed[31:28] : 4'h0, seed[3:0], seed[AW+7:8], b};
                push <= 1'b1;
                @(posedge core_clk);
            end
            push <= 1'b0;
            for (int k = 0; exp_q.size() != 0; k++) begin
                if (k == 2000) begin
                    num_errors++;
                    end_of_test();
                end
                @(posedge core_clk);
            end
            $display("test %0d done", t);
        end
        end_of_test();
    end
endmodule : test_cfdt_decoder
